// *** rtl/pssq_pkg.sv ***
// Notes on behaviour
// - Rectifier soft start once or every enable
// - Blanking register bit disables rectifier soft start
// - Rectifier drives delayed 0-315 ns, 5 ns
// - Light load disables rectifiers and shed outputs
// - Debounce blocks mode change within interval
// - Leaving light load re-enables after selected time
// - Light-load filter used in light-load mode in run state
// - Single max modulation limit, no minimum
// - Output switch gate polarity selectable
// - Power-on request source; 00 means always
// - Turn-on delay before reference ramp
// - Ramp time selectable 5 ms to 100 ms
// - Precharge start from sensed voltage, shorter ramp
// - Undervoltage flag clears above limit
// - Switch on at threshold, move to remote
// - Power-good after debounce, mask bit 7 zero
// - Faults blanked during soft start per bits, line fault always
// - Undervoltage blanked for debounce, logged, read clears
// - Local start uses startup filter, remote normal
// - At 12.5 percent check load, pick filter
// - Force startup filter; hold off light-load filter
// - Rectifier duty rises 40 ns per cycle
// - Light-load filter only below current threshold
// - Switch threshold 0, -0.5, -1, -2 percent
package pssq_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RAMP, ST_RUN} pssq_state_t;

   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_SS_BLANK = 10'h00F;
   localparam logic [9:0] IDX_FIRST_FLAG = 10'h010;
   localparam logic [9:0] IDX_ON_CTRL = 10'h02C;
   localparam logic [9:0] IDX_GATE_CFG = 10'h02D;
   localparam logic [9:0] IDX_MOD_LIMIT = 10'h02E;
   localparam logic [9:0] IDX_SWITCH_THR = 10'h030;
   localparam logic [9:0] IDX_SENSE_CFG = 10'h033;
   localparam logic [9:0] IDX_UV_LIMIT = 10'h034;
   localparam logic [9:0] IDX_LL_THR = 10'h03B;
   localparam logic [9:0] IDX_RECT_SS = 10'h054;
   localparam logic [9:0] IDX_SS_RAMP = 10'h05F;
   localparam logic [9:0] IDX_RECT_DLY = 10'h079;
   localparam logic [9:0] IDX_PG_MASK1 = 10'h07B;
   localparam logic [9:0] IDX_PG_MASK2 = 10'h07C;
   localparam logic [9:0] IDX_LL_DEB = 10'h07D;
   localparam logic [9:0] IDX_USER_CTRL = 10'h080;
   localparam logic [9:0] IDX_STATUS = 10'h081;
   localparam logic [7:0] RST_REG = 8'h00;

   // Field positions
   localparam int RECT_SS_EN = 0;
   localparam int RECT_SS_EVERY = 1;
   localparam int BLANK_RECT_SS = 7;
   localparam int ON_FORCE_SSF = 0;
   localparam int ON_NO_LL_SS = 1;
   localparam int GATE_POL = 1;
   localparam int SENSE_REMOTE_ONLY = 2;
   localparam int SS_PRECHARGE = 4;
   localparam int PG_MASK_SS = 7;
   localparam int UC_MOD_EN = 6;
   localparam int UC_SW_ON = 7;
   localparam logic [1:0] SRC_ALWAYS = 2'h0;
   localparam logic [1:0] SRC_PIN = 2'h1;
   localparam logic [1:0] SRC_SOFT = 2'h2;
   localparam logic [7:0] FIRST_ID_UV = 8'h01;

   // Filter selection codes
   localparam logic [1:0] FILT_NORMAL = 2'h0;
   localparam logic [1:0] FILT_STARTUP = 2'h1;
   localparam logic [1:0] FILT_LIGHT = 2'h2;

   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int RECT_STEP_NS = 40;
   localparam logic [9:0] RECT_STEP_CYCLES = 10'(RECT_STEP_NS / CLK_PERIOD_NS);
   localparam int RECT_DLY_STEP_NS = 5;
   localparam int RECT_DLY_MAX_NS = 315;
   localparam int RECT_DLY_DEPTH = RECT_DLY_MAX_NS / CLK_PERIOD_NS + 1;
   localparam int SS_BASE_NS = 5_000_000;
   localparam int LL_EXIT_BASE_NS = 37_500;
   localparam int REF_W = 12;
   localparam logic [11:0] REF_NOM = 12'h0800;
   localparam int SS_STEP_CYCLES = SS_BASE_NS / CLK_PERIOD_NS / int'(REF_NOM);
endpackage

// *** rtl/pssq_sequencer.sv ***
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module pssq_sequencer
   import pssq_pkg::*;
#(
   parameter int TURN_ON_UNIT_CYCLES = 250_000,
   parameter int LL_DEB_UNIT_CYCLES = 25_000,
   parameter int LL_EXIT_CYCLES = LL_EXIT_BASE_NS / CLK_PERIOD_NS,
   parameter int PG_UNIT_CYCLES = 25_000,
   parameter int UV_DEBOUNCE_CYCLES = 250_000
)(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Supply and request
   input wire logic core_supply_rail_ok_i,
   input wire logic power_on_request_i,
   // Sensed voltages, same scale as reference; current against light-load threshold
   input wire logic [11:0] local_voltage_sense_i,
   input wire logic [11:0] switch_side_voltage_sense_i,
   input wire logic [11:0] remote_voltage_sense_i,
   input wire logic [7:0] output_current_sense_i,
   // Raw fault flags: line, temp, external, over-volt, over-current
   input wire logic [4:0] fault_raw_i,
   // Power stage
   input wire logic switching_cycle_i,
   input wire logic rectifier_raw_one_i,
   input wire logic rectifier_raw_two_i,
   input wire logic [5:0] pwm_raw_i,
   input wire logic [7:0] modulation_i,
   output logic rectifier_drive_one_o,
   output logic rectifier_drive_two_o,
   output logic [9:0] rectifier_duty_limit_o,
   output logic [5:0] pwm_o,
   output logic [7:0] modulation_o,
   output logic oring_output_switch_o,
   // Loop control
   output logic [11:0] reference_o,
   output logic remote_sense_sel_o,
   output logic [1:0] filter_sel_o,
   output logic [4:0] fault_active_o,
   output logic uv_flag_o,
   output logic uv_fault_o,
   // Open-drain power good
   output logic [1:0] power_good_outputs_o,
   output logic [1:0] power_good_outputs_oe_o
);
   typedef struct packed {
      pssq_state_t st;
      logic [7:0] ss_blank, first_flag, on_ctrl, gate_cfg, mod_limit, switch_thr;
      logic [7:0] sense_cfg, uv_limit, ll_thr, rect_ss, ss_ramp, rect_dly;
      logic [7:0] pg_mask1, pg_mask2, ll_deb, user_ctrl;
      logic [31:0] rdata;
      logic [31:0] tmr;
      logic [31:0] uv_tmr;
      logic [11:0] ref_v;
      logic eval_done, ll_lock, ss_done, gate, uv_fault;
      logic ll_mode;
      logic [31:0] ll_tmr;
      logic [31:0] exit_tmr;
      logic rect_once, rect_en;
      logic [9:0] rect_duty;
      logic [1:0][31:0] pg_tmr;
      logic [1:0] pg;
      logic [RECT_DLY_DEPTH-1:0] dl_one, dl_two;
      logic [7:0] mod_q;
      logic [5:0] pwm_q;
      logic drv_one, drv_two;
   } pssq_regs_t;

   pssq_regs_t r;
   pssq_regs_t next_r;

   function automatic logic [7:0] ss_mult(input logic [2:0] code);
      case (code)
         3'h0: ss_mult = 8'h01;
         3'h1: ss_mult = 8'h02;
         3'h2: ss_mult = 8'h04;
         3'h3: ss_mult = 8'h06;
         3'h4: ss_mult = 8'h08;
         3'h5: ss_mult = 8'h0a;
         3'h6: ss_mult = 8'h10;
         default: ss_mult = 8'h14;
      endcase
   endfunction

   function automatic logic [11:0] switch_margin(input logic [1:0] code);
      case (code)
         2'h0: switch_margin = 12'h000;
         2'h1: switch_margin = 12'(int'(REF_NOM) / 200);
         2'h2: switch_margin = 12'(int'(REF_NOM) / 100);
         default: switch_margin = 12'(int'(REF_NOM) / 50);
      endcase
   endfunction

   function automatic logic [6:0] dly_taps(input logic [5:0] code);
      dly_taps = 7'((int'(code) * RECT_DLY_STEP_NS) / CLK_PERIOD_NS);
   endfunction

   function automatic logic [7:0] reg_read(input pssq_regs_t s, input logic [9:0] idx);
      case (idx)
         IDX_SS_BLANK: reg_read = s.ss_blank;
         IDX_FIRST_FLAG: reg_read = s.first_flag;
         IDX_ON_CTRL: reg_read = s.on_ctrl;
         IDX_GATE_CFG: reg_read = s.gate_cfg;
         IDX_MOD_LIMIT: reg_read = s.mod_limit;
         IDX_SWITCH_THR: reg_read = s.switch_thr;
         IDX_SENSE_CFG: reg_read = s.sense_cfg;
         IDX_UV_LIMIT: reg_read = s.uv_limit;
         IDX_LL_THR: reg_read = s.ll_thr;
         IDX_RECT_SS: reg_read = s.rect_ss;
         IDX_SS_RAMP: reg_read = s.ss_ramp;
         IDX_RECT_DLY: reg_read = s.rect_dly;
         IDX_PG_MASK1: reg_read = s.pg_mask1;
         IDX_PG_MASK2: reg_read = s.pg_mask2;
         IDX_LL_DEB: reg_read = s.ll_deb;
         IDX_USER_CTRL: reg_read = s.user_ctrl;
         IDX_STATUS: reg_read = {s.ss_done, s.gate, s.ll_mode, s.uv_fault, s.pg, 2'(s.st)};
         default: reg_read = 8'h00;
      endcase
   endfunction

   function automatic logic idx_mapped(input logic [9:0] idx);
      idx_mapped = (idx == IDX_SS_BLANK) || (idx == IDX_FIRST_FLAG) || (idx == IDX_ON_CTRL)
         || (idx == IDX_GATE_CFG) || (idx == IDX_MOD_LIMIT) || (idx == IDX_SWITCH_THR)
         || (idx == IDX_SENSE_CFG) || (idx == IDX_UV_LIMIT) || (idx == IDX_LL_THR)
         || (idx == IDX_RECT_SS) || (idx == IDX_SS_RAMP) || (idx == IDX_RECT_DLY)
         || (idx == IDX_PG_MASK1) || (idx == IDX_PG_MASK2) || (idx == IDX_LL_DEB)
         || (idx == IDX_USER_CTRL) || (idx == IDX_STATUS);
   endfunction

   logic [9:0] idx;
   logic access_done;
   logic request;
   logic remote;
   logic in_ss;
   logic ll_below;
   logic uv_below;
   logic outputs_on;
   logic [31:0] turn_on_cycles;
   logic [31:0] step_cycles;
   logic [31:0] ll_deb_cycles;
   logic [11:0] sensed;
   logic [12:0] local_plus;
   logic [4:0] blank;

   assign idx = paddr_i[11:2];
   assign access_done = psel_i && penable_i;
   assign pready_o = 1'b1;
   assign pslverr_o = access_done && !idx_mapped(idx);
   assign remote = r.gate || r.sense_cfg[SENSE_REMOTE_ONLY];
   assign in_ss = (r.st == ST_DELAY) || (r.st == ST_RAMP);
   // light load only below current threshold
   assign ll_below = output_current_sense_i < {r.ll_thr[2:0], 5'h00};
   assign uv_below = local_voltage_sense_i <= {r.uv_limit[6:0], 5'h00};
   assign outputs_on = !r.ll_mode && (r.exit_tmr == 32'h0000_0000);
   assign turn_on_cycles = (r.on_ctrl[4:3] == 2'h0) ? 32'h0000_0000
      : 32'(TURN_ON_UNIT_CYCLES) << (2 * (r.on_ctrl[4:3] - 2'h1));
   // per-step interval scales the total ramp time
   assign step_cycles = 32'(SS_STEP_CYCLES) * 32'(ss_mult(r.ss_ramp[7:5]));
   assign ll_deb_cycles = 32'(LL_DEB_UNIT_CYCLES) << r.ll_deb[5:4];
   assign sensed = remote ? remote_voltage_sense_i : local_voltage_sense_i;
   assign local_plus = {1'b0, local_voltage_sense_i} + {1'b0, switch_margin(r.switch_thr[6:5])};
   // line sense always blanked in soft start, others per bit
   assign blank = in_ss ? {1'b1, r.ss_blank[3:0]} : 5'h00;

   always_comb
   begin
      logic rect_req;
      logic rect_ss_on;
      logic pg_cond;
      logic [7:0] mask;
      rect_req = 1'b0;
      rect_ss_on = 1'b0;
      pg_cond = 1'b0;
      mask = 8'h00;
      next_r = r;

      // APB: read data staged in setup phase, writes on access
      if (psel_i && !penable_i)
      begin
         next_r.rdata = {24'h00_0000, reg_read(r, idx)};
      end
      if (access_done && pwrite_i)
      begin
         case (idx)
            IDX_SS_BLANK: next_r.ss_blank = pwdata_i[7:0];
            IDX_ON_CTRL: next_r.on_ctrl = pwdata_i[7:0];
            IDX_GATE_CFG: next_r.gate_cfg = pwdata_i[7:0];
            IDX_MOD_LIMIT: next_r.mod_limit = pwdata_i[7:0];
            IDX_SWITCH_THR: next_r.switch_thr = pwdata_i[7:0];
            IDX_SENSE_CFG: next_r.sense_cfg = pwdata_i[7:0];
            IDX_UV_LIMIT: next_r.uv_limit = pwdata_i[7:0];
            IDX_LL_THR: next_r.ll_thr = pwdata_i[7:0];
            IDX_RECT_SS: next_r.rect_ss = pwdata_i[7:0];
            IDX_SS_RAMP: next_r.ss_ramp = pwdata_i[7:0];
            IDX_RECT_DLY: next_r.rect_dly = pwdata_i[7:0];
            IDX_PG_MASK1: next_r.pg_mask1 = pwdata_i[7:0];
            IDX_PG_MASK2: next_r.pg_mask2 = pwdata_i[7:0];
            IDX_LL_DEB: next_r.ll_deb = pwdata_i[7:0];
            IDX_USER_CTRL: next_r.user_ctrl = pwdata_i[7:0];
            default: next_r.ss_blank = r.ss_blank;
         endcase
      end
      // reading first-flag clears the false fault
      if (access_done && !pwrite_i && (idx == IDX_FIRST_FLAG))
      begin
         next_r.first_flag = 8'h00;
         next_r.uv_fault = 1'b0;
      end

      case (r.on_ctrl[7:6])
         SRC_ALWAYS: request = core_supply_rail_ok_i;
         SRC_PIN: request = core_supply_rail_ok_i && power_on_request_i;
         SRC_SOFT: request = core_supply_rail_ok_i && r.user_ctrl[UC_SW_ON];
         default: request = core_supply_rail_ok_i && power_on_request_i && r.user_ctrl[UC_SW_ON];
      endcase

      unique case (r.st)
         ST_IDLE:
         begin
            next_r.ref_v = 12'h000;
            next_r.ss_done = 1'b0;
            next_r.tmr = 32'h0000_0000;
            if (request)
            begin
               next_r.st = ST_DELAY;
            end
         end
         ST_DELAY:
         begin
            next_r.tmr = r.tmr + 32'h0000_0001;
            if (!request)
            begin
               next_r.st = ST_IDLE;
            end
            else if (r.tmr >= turn_on_cycles)
            begin
               next_r.st = ST_RAMP;
               next_r.tmr = 32'h0000_0000;
               next_r.uv_tmr = 32'h0000_0000;
               next_r.eval_done = 1'b0;
               next_r.ll_lock = 1'b0;
               // precharge start from active sense point
               next_r.ref_v = r.ss_ramp[SS_PRECHARGE] ? ((sensed > REF_NOM) ? REF_NOM : sensed) : 12'h000;
            end
         end
         ST_RAMP:
         begin
            next_r.tmr = r.tmr + 32'h0000_0001;
            if (!request)
            begin
               next_r.st = ST_IDLE;
            end
            else if (r.ref_v >= REF_NOM)
            begin
               next_r.st = ST_RUN;
               next_r.ss_done = 1'b1;
               next_r.ll_lock = 1'b0;
            end
            else if (r.tmr + 32'h0000_0001 >= step_cycles)
            begin
               next_r.tmr = 32'h0000_0000;
               next_r.ref_v = r.ref_v + 12'h001;
            end
            // load check once at 12.5 percent
            if (!r.eval_done && (r.ref_v >= (REF_NOM >> 3)))
            begin
               next_r.eval_done = 1'b1;
               // light filter held off when selected
               next_r.ll_lock = ll_below && !r.on_ctrl[ON_NO_LL_SS];
            end
            if (uv_below)
            begin
               next_r.uv_tmr = r.uv_tmr + 32'h0000_0001;
               if (r.uv_tmr >= 32'(UV_DEBOUNCE_CYCLES))
               begin
                  next_r.uv_fault = 1'b1;
                  if (r.first_flag == 8'h00)
                  begin
                     next_r.first_flag = FIRST_ID_UV;
                  end
               end
            end
         end
         ST_RUN:
         begin
            if (!request)
            begin
               next_r.st = ST_IDLE;
            end
         end
      endcase

      // switch on when forward drop beats threshold
      // threshold is a negative margin on local sense
      next_r.gate = ((r.st == ST_RAMP) || (r.st == ST_RUN))
         && (local_plus > {1'b0, switch_side_voltage_sense_i});

      if (r.ll_tmr < ll_deb_cycles)
      begin
         next_r.ll_tmr = r.ll_tmr + 32'h0000_0001;
      end
      if (r.exit_tmr != 32'h0000_0000)
      begin
         next_r.exit_tmr = r.exit_tmr - 32'h0000_0001;
      end
      if (r.st == ST_IDLE)
      begin
         next_r.ll_mode = 1'b0;
         next_r.exit_tmr = 32'h0000_0000;
      end
      else if ((r.ll_tmr >= ll_deb_cycles) && (ll_below != r.ll_mode))
      begin
         next_r.ll_mode = ll_below;
         next_r.ll_tmr = 32'h0000_0000;
         if (!ll_below)
         begin
            next_r.exit_tmr = 32'(LL_EXIT_CYCLES) << r.ll_deb[3:2];
         end
      end

      rect_req = ((r.st == ST_RAMP) || (r.st == ST_RUN)) && outputs_on;
      next_r.rect_en = rect_req;
      // once only or on every enable
      // blanking bit overrides rectifier soft start
      rect_ss_on = r.rect_ss[RECT_SS_EN] && !r.ss_blank[BLANK_RECT_SS]
         && (r.rect_ss[RECT_SS_EVERY] || !r.rect_once);
      if (rect_req && !r.rect_en)
      begin
         next_r.rect_once = 1'b1;
         next_r.rect_duty = rect_ss_on ? 10'h000 : 10'h3ff;
      end
      // duty limit rises 40 ns each switching cycle
      else if (r.rect_en && switching_cycle_i && (r.rect_duty != 10'h3ff))
      begin
         next_r.rect_duty = (r.rect_duty > 10'h3ff - RECT_STEP_CYCLES) ? 10'h3ff : r.rect_duty + RECT_STEP_CYCLES;
      end

      // constant delay on both rectifier drives
      next_r.dl_one = {r.dl_one[RECT_DLY_DEPTH-2:0], rectifier_raw_one_i && rect_req};
      next_r.dl_two = {r.dl_two[RECT_DLY_DEPTH-2:0], rectifier_raw_two_i && rect_req};
      if (dly_taps(r.rect_dly[5:0]) == 7'h00)
      begin
         next_r.drv_one = rectifier_raw_one_i && rect_req;
         next_r.drv_two = rectifier_raw_two_i && rect_req;
      end
      else
      begin
         next_r.drv_one = r.dl_one[dly_taps(r.rect_dly[5:0]) - 7'h01];
         next_r.drv_two = r.dl_two[dly_taps(r.rect_dly[5:0]) - 7'h01];
      end

      // configured outputs shed in light load
      next_r.pwm_q = pwm_raw_i & ~(r.user_ctrl[5:0] & {6{!outputs_on}});

      // single upper bound, no lower one
      if (r.user_ctrl[UC_MOD_EN])
      begin
         next_r.mod_q = (modulation_i > r.mod_limit) ? r.mod_limit : modulation_i;
      end
      else
      begin
         next_r.mod_q = 8'h00;
      end

      // power good after debounce, soft-start flag unmasked
      for (int i = 0; i < 2; i++)
      begin
         mask = (i == 0) ? r.pg_mask1 : r.pg_mask2;
         pg_cond = r.ss_done && !mask[PG_MASK_SS] && ((fault_raw_i & ~blank) == 5'h00) && !r.uv_fault;
         if (!pg_cond)
         begin
            next_r.pg_tmr[i] = 32'h0000_0000;
            next_r.pg[i] = 1'b0;
         end
         else if (r.pg_tmr[i] >= 32'(PG_UNIT_CYCLES) * 32'(r.gate_cfg[7:4]))
         begin
            next_r.pg[i] = 1'b1;
         end
         else
         begin
            next_r.pg_tmr[i] = r.pg_tmr[i] + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end

   always_comb
   begin
      filter_sel_o = FILT_NORMAL;
      if (r.st == ST_RAMP)
      begin
         // startup filter from local, normal from remote
         // force bit keeps startup filter on remote
         if (r.ll_lock)
         begin
            filter_sel_o = FILT_LIGHT;
         end
         else if (!remote || r.on_ctrl[ON_FORCE_SSF])
         begin
            filter_sel_o = FILT_STARTUP;
         end
      end
      else if ((r.st == ST_RUN) && r.ll_mode)
      begin
         filter_sel_o = FILT_LIGHT;
      end
   end

   assign prdata_o = r.rdata;
   assign reference_o = r.ref_v;
   assign remote_sense_sel_o = remote;
   // gate polarity, bit set means active high
   assign oring_output_switch_o = r.gate_cfg[GATE_POL] ? r.gate : !r.gate;
   assign rectifier_drive_one_o = r.drv_one;
   assign rectifier_drive_two_o = r.drv_two;
   assign rectifier_duty_limit_o = r.rect_en ? r.rect_duty : 10'h000;
   assign pwm_o = r.pwm_q;
   assign modulation_o = r.mod_q;
   assign fault_active_o = fault_raw_i & ~blank;
   // flag clears once local sense exceeds limit
   assign uv_flag_o = (r.st != ST_IDLE) && uv_below;
   assign uv_fault_o = r.uv_fault;
   assign power_good_outputs_o = 2'h0;
   assign power_good_outputs_oe_o = ~r.pg;
endmodule

// *** verif/pssq_monitor.sv ***
`timescale 1ns/1ps
module pssq_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Watched ports
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic core_supply_rail_ok_i,
   input wire logic [4:0] fault_raw_i,
   input wire logic [31:0] prdata_o,
   input wire logic pslverr_o,
   input wire logic [9:0] rectifier_duty_limit_o,
   input wire logic [11:0] reference_o,
   input wire logic [1:0] filter_sel_o,
   input wire logic [4:0] fault_active_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_err; pslverr_o |-> psel_i && penable_i; endproperty
   a_err: assert property (p_err) else $error("bus error outside access");
   property p_hi; prdata_o[31:8] == 24'h00_0000; endproperty
   a_hi: assert property (p_hi) else $error("read data upper bits set");
   property p_mono; !$stable(reference_o) |-> reference_o > $past(reference_o) || reference_o == 12'h000; endproperty
   a_mono: assert property (p_mono) else $error("reference fell");
   property p_step;
      reference_o > $past(reference_o) && $past(reference_o) != 12'h000 |-> reference_o == $past(reference_o) + 12'h001;
   endproperty
   a_step: assert property (p_step) else $error("reference step size");
   property p_blank; (fault_active_o & ~fault_raw_i) == 5'h00; endproperty
   a_blank: assert property (p_blank) else $error("fault without raw cause");
   property p_off; !core_supply_rail_ok_i |=> ##1 reference_o == 12'h000; endproperty
   a_off: assert property (p_off) else $error("reference kept without supply");
   property p_duty0; !core_supply_rail_ok_i [*3] |-> rectifier_duty_limit_o == 10'h000; endproperty
   a_duty0: assert property (p_duty0) else $error("rectifier duty while off");
   property p_duty;
      rectifier_duty_limit_o > $past(rectifier_duty_limit_o) && rectifier_duty_limit_o != 10'h3FF
         |-> rectifier_duty_limit_o == $past(rectifier_duty_limit_o) + 10'h00A;
   endproperty
   a_duty: assert property (p_duty) else $error("rectifier duty step");
   property p_filt; filter_sel_o != 2'h3; endproperty
   a_filt: assert property (p_filt) else $error("bad filter code");
   c_run: cover property (reference_o == 12'h800);
   c_light: cover property (filter_sel_o == 2'h2);
   c_full: cover property (rectifier_duty_limit_o == 10'h3FF);
endmodule

bind pssq_sequencer pssq_monitor mon (.clk_i, .rst_n_i, .psel_i, .penable_i, .core_supply_rail_ok_i, .fault_raw_i,
   .prdata_o, .pslverr_o, .rectifier_duty_limit_o, .reference_o, .filter_sel_o, .fault_active_o);

// *** verif/pssq_stage_model.sv ***
`timescale 1ns/1ps
module pssq_stage_model #(
   parameter logic [11:0] PRE = 12'h7C0
)(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Loop and stage
   input wire logic [11:0] reference_i,
   output logic [11:0] vout_o,
   output logic sw_cycle_o,
   output logic rect_one_o,
   output logic rect_two_o,
   output logic [5:0] pwm_o
);
   logic [4:0] phase;
   // Precharged output keeps its level until the ramp passes it
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         phase <= 5'h00;
         vout_o <= PRE;
      end
      else
      begin
         phase <= (phase == 5'h18) ? 5'h00 : phase + 5'h01;
         vout_o <= (reference_i > PRE) ? reference_i : PRE;
      end
   assign sw_cycle_o = (phase == 5'h00);
   assign rect_one_o = (phase < 5'h0C);
   assign rect_two_o = !rect_one_o;
   assign pwm_o = {6{rect_one_o}};
endmodule

// *** verif/psu_soft_start_light_load_seq_bench.sv ***
`timescale 1ns/1ps
module psu_soft_start_light_load_seq_bench;
   import pssq_pkg::*;
   logic clk_i, rst_n_i, psel_i, penable_i, pwrite_i, core_supply_rail_ok_i, pready_o, pslverr_o, err, gate;
   logic switching_cycle_i, rectifier_raw_one_i, rectifier_raw_two_i, remote_sense_sel_o, oring_output_switch_o;
   logic [11:0] paddr_i, reference_o, vout;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [7:0] output_current_sense_i, modulation_i, modulation_o;
   logic [5:0] pwm_raw_i, pwm_o;
   logic [9:0] rectifier_duty_limit_o;
   logic [1:0] filter_sel_o, power_good_outputs_oe_o;
   logic [4:0] flt, fault_active_o;
   int miscompares = 0;
   int checks_done = 0;
   int i;
   pssq_sequencer #(.TURN_ON_UNIT_CYCLES(20), .LL_DEB_UNIT_CYCLES(8), .LL_EXIT_CYCLES(10), .PG_UNIT_CYCLES(4),
      .UV_DEBOUNCE_CYCLES(50)) dut (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
      .pready_o, .pslverr_o, .core_supply_rail_ok_i, .power_on_request_i(core_supply_rail_ok_i),
      .local_voltage_sense_i(vout),
      .switch_side_voltage_sense_i(vout), .remote_voltage_sense_i(vout), .output_current_sense_i,
      .fault_raw_i(flt), .switching_cycle_i, .rectifier_raw_one_i, .rectifier_raw_two_i, .pwm_raw_i, .modulation_i,
      .rectifier_drive_one_o(), .rectifier_drive_two_o(), .rectifier_duty_limit_o, .pwm_o, .modulation_o,
      .oring_output_switch_o, .reference_o, .remote_sense_sel_o, .filter_sel_o, .fault_active_o, .uv_flag_o(),
      .uv_fault_o(), .power_good_outputs_o(), .power_good_outputs_oe_o);
   pssq_stage_model stage (.clk_i, .rst_n_i, .reference_i(reference_o), .vout_o(vout), .sw_cycle_o(switching_cycle_i),
      .rect_one_o(rectifier_raw_one_i), .rect_two_o(rectifier_raw_two_i), .pwm_o(pwm_raw_i));
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bound(input logic ok);
      if (!ok)
      begin
         miscompares++;
         $display("wrong value at %0t: wait expired", $time);
         final_report();
      end
   endtask
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
      int n;
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= {idx, 2'b00};
      pwdata_i <= {24'h00_0000, d};
      @(posedge clk_i);
      penable_i <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk_i);
         if (pready_o === 1'b1)
            break;
      end
      bound(n < 20);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask
   initial
   begin
      rst_n_i = 1'b0;
      {psel_i, penable_i, pwrite_i, core_supply_rail_ok_i} = 4'h0;
      paddr_i = 12'h000;
      pwdata_i = 32'h0000_0000;
      flt = 5'h11;
      output_current_sense_i = 8'h80;
      modulation_i = 8'hF0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      apb(1'b0, IDX_LL_DEB, 8'h00);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 10'h001, 8'h00);
      chk({31'h0000_0000, err}, 32'h0000_0001);
      apb(1'b1, IDX_UV_LIMIT, 8'h05);
      apb(1'b0, IDX_UV_LIMIT, 8'h00);
      chk(rd, 32'h0000_0005);
      apb(1'b1, IDX_STATUS, 8'hFF);
      apb(1'b0, IDX_STATUS, 8'h00);
      chk(rd, 32'h0000_0000);
      apb(1'b1, IDX_SS_RAMP, 8'h10);
      apb(1'b1, IDX_SENSE_CFG, 8'h04);
      apb(1'b1, IDX_ON_CTRL, 8'h01);
      apb(1'b1, IDX_RECT_SS, 8'h03);
      apb(1'b1, IDX_GATE_CFG, 8'h10);
      core_supply_rail_ok_i <= 1'b1;
      for (i = 0; i < 200 && reference_o === 12'h000; i++) @(posedge clk_i);
      bound(i < 200);
      chk(32'(reference_o[11:6]), 32'h0000_001F);
      chk(32'(filter_sel_o), 32'(FILT_STARTUP));
      chk(32'(remote_sense_sel_o), 32'h0000_0001);
      chk(32'(fault_active_o), 32'h0000_0001);
      flt <= 5'h00;
      for (i = 0; i < 60000 && reference_o !== REF_NOM; i++) @(posedge clk_i);
      bound(i < 60000);
      repeat (2) @(posedge clk_i);
      chk(32'(filter_sel_o), 32'(FILT_NORMAL));
      for (i = 0; i < 50 && power_good_outputs_oe_o !== 2'b00; i++) @(posedge clk_i);
      bound(i < 50);
      chk(32'(rectifier_duty_limit_o), 32'h0000_03FF);
      gate = oring_output_switch_o;
      apb(1'b1, IDX_GATE_CFG, 8'h12);
      chk(32'(oring_output_switch_o), 32'(!gate));
      apb(1'b1, IDX_MOD_LIMIT, 8'h20);
      apb(1'b1, IDX_USER_CTRL, 8'h41);
      apb(1'b1, IDX_LL_THR, 8'h02);
      chk(32'(modulation_o), 32'h0000_0020);
      output_current_sense_i <= 8'h10;
      for (i = 0; i < 100 && filter_sel_o !== FILT_LIGHT; i++) @(posedge clk_i);
      bound(i < 100);
      repeat (30) @(posedge clk_i);
      chk(32'(rectifier_duty_limit_o), 32'h0000_0000);
      chk(32'(pwm_o[0]), 32'h0000_0000);
      output_current_sense_i <= 8'h80;
      for (i = 0; i < 300 && rectifier_duty_limit_o === 10'h000; i++) @(posedge clk_i);
      bound(i < 300);
      chk(32'(i >= 10), 32'h0000_0001);
      chk(32'(rectifier_duty_limit_o), 32'h0000_000A);
      core_supply_rail_ok_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(32'(reference_o), 32'h0000_0000);
      chk(32'(power_good_outputs_oe_o), 32'h0000_0003);
      final_report();
   end
endmodule
